// *** rtl/cpw_pkg.sv ***
// constants and types shared by the cascaded pulse and warm-up timer
package cpw_pkg;
  // upper-stage control field positions
  localparam int unsigned UPPER_INIT_BIT = 7;
  localparam int unsigned UPPER_RUN_BIT  = 3;
  localparam int unsigned MODE_MSB       = 2;
  // lower-stage control clock-select field
  localparam int unsigned CLKSEL_MSB     = 6;
  localparam int unsigned CLKSEL_LSB     = 4;
  // mode field codes
  localparam logic [2:0]  LOWER_MODE_CASCADE = 3'h3;
  localparam logic [2:0]  UPPER_MODE_PULSE   = 3'h7;
  localparam logic [2:0]  UPPER_MODE_WARMUP  = 3'h5;
  // clock-select codes
  localparam logic [2:0]  CLK_DIV2048 = 3'h0;
  localparam logic [2:0]  CLK_DIV128  = 3'h1;
  localparam logic [2:0]  CLK_DIV32   = 3'h2;
  localparam logic [2:0]  CLK_DIV8    = 3'h3;
  localparam logic [2:0]  CLK_LOWFREQ = 3'h4;
  localparam logic [2:0]  CLK_DIV2    = 3'h5;
  localparam logic [2:0]  CLK_FULL    = 3'h6;
  localparam logic [2:0]  CLK_EXTPIN  = 3'h7;
  // reset values and default prescaler width
  localparam logic        FLIPFLOP_RESET = 1'b0;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam int unsigned PRESC_W_DEF    = 11;
  // warm-up figures at a 32.768 kHz low clock
  localparam logic [15:0] WARMUP_MIN_CMP = 16'h0100;
  localparam logic [15:0] WARMUP_MAX_CMP = 16'hFF00;
  localparam real         WARMUP_MIN_MS  = 7.81;
  localparam real         WARMUP_MAX_S   = 1.99;

  typedef enum logic [2:0] {
    CPW_MODE_OFF    = 3'b001,
    CPW_MODE_PULSE  = 3'b010,
    CPW_MODE_WARMUP = 3'b100
  } cpw_mode_t;

  typedef struct packed {
    logic [15:0] width;
    logic [15:0] period;
  } cpw_cmp_t;
endpackage

// *** rtl/cpw_count_src.sv ***
// count tick source: prescaler taps, low clock and external pin edges
`timescale 1ns/1ns
`default_nettype none
module cpw_count_src #(
  parameter int unsigned PRESC_W = cpw_pkg::PRESC_W_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] clk_sel,
  input  wire logic       ext_pin,
  input  wire logic       low_freq_pin,
  output var  logic       tick
);
  if (PRESC_W < 11) begin : g_chk
    $error("cpw_count_src: PRESC_W must be at least 11");
  end

  logic [PRESC_W-1:0] presc_r;
  logic [PRESC_W-1:0] presc_nxt;
  logic [2:0]         ext_sy_r;
  logic [2:0]         ext_sy_nxt;
  logic [2:0]         lf_sy_r;
  logic [2:0]         lf_sy_nxt;
  logic               tick_nxt;

  always_comb begin
    presc_nxt  = presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};
    ext_sy_nxt = {ext_sy_r[1:0], ext_pin};
    lf_sy_nxt  = {lf_sy_r[1:0], low_freq_pin};
    // edge detect looks only at stages 1 and 2, never the first flop
    unique case (clk_sel)
      cpw_pkg::CLK_DIV2048: tick_nxt = &presc_r[10:0];
      cpw_pkg::CLK_DIV128:  tick_nxt = &presc_r[6:0];
      cpw_pkg::CLK_DIV32:   tick_nxt = &presc_r[4:0];
      cpw_pkg::CLK_DIV8:    tick_nxt = &presc_r[2:0];
      cpw_pkg::CLK_LOWFREQ: tick_nxt = lf_sy_r[1] & ~lf_sy_r[2];
      cpw_pkg::CLK_DIV2:    tick_nxt = presc_r[0];
      cpw_pkg::CLK_FULL:    tick_nxt = 1'b1;
      cpw_pkg::CLK_EXTPIN:  tick_nxt = ~ext_sy_r[1] & ext_sy_r[2]; // R3
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r  <= '0;
      ext_sy_r <= 3'h0;
      lf_sy_r  <= 3'h0;
      tick     <= 1'b0;
    end else begin
      presc_r  <= presc_nxt;
      ext_sy_r <= ext_sy_nxt;
      lf_sy_r  <= lf_sy_nxt;
      tick     <= tick_nxt;
    end
  end
endmodule // cpw_count_src
`default_nettype wire

// *** rtl/cpw_timer.sv ***
// cascaded 16-bit pulse generator and warm-up counter
`timescale 1ns/1ns
`default_nettype none
// Function
// R1: pulse mode: width match toggles flip-flop
// R2: period match toggles, clears, raises interrupt
// R3: external count levels last two machine cycles
// R4: initial level loadable; reset clears flip-flop
// R5: pin is inverse of flip-flop
// R6: software writes low byte then high
// R7: compares unbuffered; no change while running
// R8: software sets port latch to one
// R9: stop holds pin; level changed afterwards
// R10: upper bit 3 starts and stops counting
// R11: upper bit 7 initial level; clear drives high
// R12: 33H, 057H, 05FH select pulse mode
// R13: warm-up mode: one 16-bit counter
// R14: warm-up compares upper period byte only
// R15: warm-up keeps initial-level bits at zero
// R16: warm-up match clears counter, raises interrupt
// R17: slow switch sequence done by software
// R18: 0100H gives 7.81 ms, FF00H 1.99 s
// R19: 05H and 43H select slow warm-up
// R20: fast switch sequence done by software
// R21: lower stage carries into upper stage
module cpw_timer #(
  parameter int unsigned PRESC_W = cpw_pkg::PRESC_W_DEF
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  LOWER_STAGE_CONTROL,
  input  wire logic [7:0]  UPPER_STAGE_CONTROL,
  input  wire logic [7:0]  WIDTH_COMPARE_LOW,
  input  wire logic [7:0]  WIDTH_COMPARE_HIGH,
  input  wire logic [7:0]  PERIOD_COMPARE_LOW,
  input  wire logic [7:0]  PERIOD_COMPARE_HIGH,
  input  wire logic        EXTERNAL_COUNT_PIN,
  input  wire logic        LOW_FREQ_CLOCK,
  output var  logic        PULSE_OUT_PIN_N,
  output var  logic        CASCADE_TIMER_IRQ,
  output var  logic [15:0] COUNT_VALUE,
  output var  logic        RUNNING
);
  cpw_pkg::cpw_mode_t mode;
  cpw_pkg::cpw_cmp_t  cmp;
  logic        tick;
  logic        run;
  logic        init_lvl;
  logic [7:0]  lo_r;
  logic [7:0]  lo_nxt;
  logic [7:0]  hi_r;
  logic [7:0]  hi_nxt;
  logic        ff_r;
  logic        ff_nxt;
  logic        pin_n_nxt;
  logic        irq_nxt;
  logic        run_prev_r;
  logic        init_prev_r;
  logic [15:0] inc;
  logic        adv;
  logic        width_hit;
  logic        period_hit;
  logic        warm_hit;

  cpw_count_src #(
    .PRESC_W (PRESC_W)
  ) u_src (
    .clk          (MCLK),
    .rst_n        (RST_N),
    .clk_sel      (LOWER_STAGE_CONTROL[cpw_pkg::CLKSEL_MSB:cpw_pkg::CLKSEL_LSB]),
    .ext_pin      (EXTERNAL_COUNT_PIN),
    .low_freq_pin (LOW_FREQ_CLOCK),
    .tick         (tick)
  );

  // compare registers are live, not double-buffered
  always_comb begin
    cmp.width  = {WIDTH_COMPARE_HIGH, WIDTH_COMPARE_LOW};   // R7
    cmp.period = {PERIOD_COMPARE_HIGH, PERIOD_COMPARE_LOW}; // R7
    run        = UPPER_STAGE_CONTROL[cpw_pkg::UPPER_RUN_BIT];  // R10
    init_lvl   = UPPER_STAGE_CONTROL[cpw_pkg::UPPER_INIT_BIT]; // R11
  end

  // mode decode; other timer modes leave the counter idle
  always_comb begin
    mode = cpw_pkg::CPW_MODE_OFF;
    if (LOWER_STAGE_CONTROL[cpw_pkg::MODE_MSB:0] == cpw_pkg::LOWER_MODE_CASCADE) begin
      if (UPPER_STAGE_CONTROL[cpw_pkg::MODE_MSB:0] == cpw_pkg::UPPER_MODE_PULSE) begin
        mode = cpw_pkg::CPW_MODE_PULSE;  // R12
      end else if (UPPER_STAGE_CONTROL[cpw_pkg::MODE_MSB:0] == cpw_pkg::UPPER_MODE_WARMUP) begin
        mode = cpw_pkg::CPW_MODE_WARMUP; // R19
      end
    end
  end

  always_comb begin
    inc        = {hi_r, lo_r} + 16'h0001; // R21
    adv        = run & run_prev_r & tick;
    width_hit  = (inc == cmp.width);
    period_hit = (inc == cmp.period);
    warm_hit   = (inc[15:8] == cmp.period[15:8]); // R14 R18
    lo_nxt     = lo_r;
    hi_nxt     = hi_r;
    ff_nxt     = ff_r;
    irq_nxt    = 1'b0;
    if (run && !run_prev_r) begin
      // start: counter from zero, flip-flop from the initial level
      lo_nxt = 8'h00;
      hi_nxt = 8'h00;
      ff_nxt = init_lvl; // R4
    end else if (!run && !run_prev_r && (init_lvl != init_prev_r)) begin
      // a stop cycle never reloads, so the pin holds its level there
      ff_nxt = init_lvl; // R9 R11
    end else if (adv) begin
      unique case (mode)
        cpw_pkg::CPW_MODE_PULSE: begin
          lo_nxt = inc[7:0];
          hi_nxt = inc[15:8];
          if (width_hit) begin
            ff_nxt = ~ff_nxt; // R1
          end
          if (period_hit) begin
            ff_nxt  = ~ff_nxt; // R2
            lo_nxt  = 8'h00;
            hi_nxt  = 8'h00;
            irq_nxt = 1'b1;
          end
        end
        cpw_pkg::CPW_MODE_WARMUP: begin
          lo_nxt = inc[7:0];  // R13
          hi_nxt = inc[15:8];
          if (warm_hit) begin
            lo_nxt  = 8'h00; // R16
            hi_nxt  = 8'h00;
            irq_nxt = 1'b1;
          end
        end
        cpw_pkg::CPW_MODE_OFF: begin
          lo_nxt = lo_r;
        end
        default: begin
          lo_nxt = lo_r;
        end
      endcase
    end
    pin_n_nxt = ~ff_nxt; // R5
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      lo_r              <= cpw_pkg::COUNT_RESET[7:0];
      hi_r              <= cpw_pkg::COUNT_RESET[15:8];
      ff_r              <= cpw_pkg::FLIPFLOP_RESET; // R4
      PULSE_OUT_PIN_N   <= ~cpw_pkg::FLIPFLOP_RESET;
      CASCADE_TIMER_IRQ <= 1'b0;
      COUNT_VALUE       <= cpw_pkg::COUNT_RESET;
      RUNNING           <= 1'b0;
      run_prev_r        <= 1'b0;
      init_prev_r       <= cpw_pkg::FLIPFLOP_RESET;
    end else begin
      lo_r              <= lo_nxt;
      hi_r              <= hi_nxt;
      ff_r              <= ff_nxt;
      PULSE_OUT_PIN_N   <= pin_n_nxt;
      CASCADE_TIMER_IRQ <= irq_nxt;
      COUNT_VALUE       <= {hi_nxt, lo_nxt};
      RUNNING           <= run;
      run_prev_r        <= run;
      init_prev_r       <= init_lvl;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  AST_PIN_INVERSE: assert property (PULSE_OUT_PIN_N == !ff_r) // R5
    else $error("pulse pin is not the inverse of the flip-flop");
  AST_WIDTH_TOGGLE: assert property ( // R1
    adv && mode == cpw_pkg::CPW_MODE_PULSE && width_hit && !period_hit
    |=> ff_r != $past(ff_r) && COUNT_VALUE == $past(inc))
    else $error("width match did not toggle and keep counting");
  AST_PERIOD_CLEAR: assert property ( // R2
    adv && mode == cpw_pkg::CPW_MODE_PULSE && period_hit && !width_hit
    |=> ff_r != $past(ff_r) && COUNT_VALUE == 16'h0000 && CASCADE_TIMER_IRQ)
    else $error("period match did not toggle, clear and interrupt");
  AST_WARM_CLEAR: assert property ( // R16
    adv && mode == cpw_pkg::CPW_MODE_WARMUP && warm_hit
    |=> COUNT_VALUE == 16'h0000 && CASCADE_TIMER_IRQ && $stable(ff_r))
    else $error("warm-up match did not clear and interrupt");
  AST_WARM_LOW_IGNORED: assert property ( // R14
    adv && mode == cpw_pkg::CPW_MODE_WARMUP && inc[15:8] != cmp.period[15:8]
    |=> !CASCADE_TIMER_IRQ && COUNT_VALUE == $past(inc))
    else $error("warm-up matched on the low byte");
  AST_STOP_HOLDS: assert property ( // R9
    run_prev_r && !run |=> $stable(ff_r))
    else $error("pin level changed on the stopping write");
  AST_STOPPED_FROZEN: assert property ( // R10
    !run |=> $stable(COUNT_VALUE) && !CASCADE_TIMER_IRQ)
    else $error("counter moved while stopped");
  AST_INIT_LOAD: assert property ( // R11
    !run && !run_prev_r && init_lvl != init_prev_r |=> PULSE_OUT_PIN_N == !$past(init_lvl))
    else $error("initial level not applied while stopped");
  AST_CARRY: assert property ( // R21
    adv && mode != cpw_pkg::CPW_MODE_OFF && lo_r == 8'hFF && !irq_nxt
    |=> COUNT_VALUE[15:8] == $past(hi_r) + 8'h01 && COUNT_VALUE[7:0] == 8'h00)
    else $error("lower stage did not carry into upper stage");

  COV_PULSE_PERIOD: cover property (mode == cpw_pkg::CPW_MODE_PULSE ##0 irq_nxt);
  COV_WARM_DONE:    cover property (mode == cpw_pkg::CPW_MODE_WARMUP ##0 irq_nxt);
  COV_STOP_RELEVEL: cover property ($fell(run) ##[1:20] init_lvl != init_prev_r);
endmodule // cpw_timer
`default_nettype wire

// *** verif/cpw_far_end.sv ***
// far-side model: external count pin and low-frequency oscillator
`timescale 1ns/1ns
`default_nettype none
module cpw_far_end (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] half,
  output var  logic       ext_pin,
  output var  logic       low_clk
);
  logic [7:0] cnt;
  // both run free; each level lasts half cycles, well over two machine cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 8'h00;
      ext_pin <= 1'b1;
      low_clk <= 1'b0;
    end else if (cnt == half - 8'h01) begin
      cnt     <= 8'h00;
      ext_pin <= ~ext_pin;
      low_clk <= ~low_clk;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // cpw_far_end
`default_nettype wire

// *** verif/tb_cascaded_pulse_warmup_timer.sv ***
// self-checking bench for the cascaded pulse and warm-up timer
`timescale 1ns/1ns
`default_nettype none
module tb_cascaded_pulse_warmup_timer;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  lo_ctl;
  logic [7:0]  up_ctl;
  logic [15:0] wid;
  logic [15:0] per;
  logic        ext_pin;
  logic        low_clk;
  logic        pin_n; // pin seen directly, as with its port latch at one
  logic        irq;
  logic        running;
  logic [15:0] count;
  logic [31:0] seed;
  int          bad_count;
  int          tests_run;
  logic [2:0]  sels [8] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h7, 3'h1, 3'h4, 3'h0};
  int          divs [8] = '{1, 2, 8, 32, 16, 128, 16, 2048};

  cpw_timer u_dut (.MCLK(mclk), .RST_N(rst_n), .LOWER_STAGE_CONTROL(lo_ctl),
    .UPPER_STAGE_CONTROL(up_ctl), .WIDTH_COMPARE_LOW(wid[7:0]), .WIDTH_COMPARE_HIGH(wid[15:8]),
    .PERIOD_COMPARE_LOW(per[7:0]), .PERIOD_COMPARE_HIGH(per[15:8]),
    .EXTERNAL_COUNT_PIN(ext_pin), .LOW_FREQ_CLOCK(low_clk), .PULSE_OUT_PIN_N(pin_n),
    .CASCADE_TIMER_IRQ(irq), .COUNT_VALUE(count), .RUNNING(running));
  cpw_far_end u_far (.clk(mclk), .rst_n(rst_n), .half(8'h08), .ext_pin(ext_pin),
    .low_clk(low_clk));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // every source ticks at a fixed period, so match spacing is exact
  function automatic logic [15:0] ticks(input int n, input int div);
    return 16'(n * div);
  endfunction

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_ev(input logic on_pin, input logic from, input int lim, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (n >= lim) begin
        bad_count++;
        $display("unexpected wait: expected event, seen none");
        close_out();
      end
    end while (on_pin ? pin_n === from : irq !== 1'b1);
  endtask

  task automatic run_pulse(input logic [2:0] sel, input logic lvl, input int w, input int p,
                           input int div);
    int n;
    logic [15:0] c;
    lo_ctl = {1'b0, sel, 4'h3};
    up_ctl = {lvl, 7'h57};
    wid = w[15:0];
    per = p[15:0];
    @(negedge mclk);
    up_ctl = {lvl, 7'h5f};
    @(negedge mclk);
    check_bit("start pin", ~lvl, pin_n);
    check_bit("running", 1'b1, running);
    wait_ev(1'b0, 1'b0, 40 * p * div + 4000, n);
    check_val("count at period", 16'h0000, count);
    check_bit("pin at period", ~lvl, pin_n);
    wait_ev(1'b1, ~lvl, 40 * p * div, n);
    check_val("width cycles", ticks(w, div), n[15:0]);
    check_val("count at width", w[15:0], count);
    wait_ev(1'b0, 1'b0, 40 * p * div, n);
    check_val("period cycles", ticks(p - w, div), n[15:0]);
    repeat (w * div + 1) @(negedge mclk);
    up_ctl = {lvl, 7'h57};
    @(negedge mclk);
    c = count;
    repeat (3 * div + 4) @(negedge mclk);
    check_val("count after stop", c, count);
    check_bit("pin after stop", lvl, pin_n);
    check_bit("stopped", 1'b0, running);
    // the level loads only on a change of the bit, so clear it first
    up_ctl = 8'h57;
    repeat (2) @(negedge mclk);
    check_bit("pin level kept", lvl, pin_n);
    up_ctl = 8'hd7;
    repeat (2) @(negedge mclk);
    check_bit("pin level set", 1'b0, pin_n);
    up_ctl = 8'h57;
    repeat (2) @(negedge mclk);
    check_bit("pin level cleared", 1'b1, pin_n);
  endtask

  task automatic run_warm(input logic [7:0] lo, input logic [7:0] hi, input int div);
    int n;
    int t;
    logic [31:0] r;
    r = rnd();
    t = int'(ticks(hi * 256, div));
    lo_ctl = lo;
    up_ctl = 8'h05;
    per = {hi, r[7:0]};
    @(negedge mclk);
    up_ctl = 8'h0d;
    wait_ev(1'b0, 1'b0, 20000, n);
    check_bit("warm first", 1'b1, n > t - 40 && n < t + 40);
    check_val("warm count", 16'h0000, count);
    wait_ev(1'b0, 1'b0, 20000, n);
    check_val("warm interval", ticks(hi * 256, div), n[15:0]);
    check_bit("warm pin", 1'b1, pin_n);
    up_ctl = 8'h05;
    @(negedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    int w;
    int p;
    logic [15:0] c;
    seed = 32'h0000_005a;
    bad_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    lo_ctl = 8'h00;
    up_ctl = 8'h00;
    wid = 16'h0000;
    per = 16'h0000;
    repeat (3) @(negedge mclk);
    check_bit("reset pin", 1'b1, pin_n);
    check_bit("reset irq", 1'b0, irq);
    check_val("reset count", 16'h0000, count);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      w = 1 + int'(rnd() % 4);
      p = w + 2 + int'(rnd() % 4);
      // first case crosses the byte boundary to exercise the carry
      if (i == 0) begin
        w += 256;
        p += 256;
      end
      // slowest tap kept short so the run stays bounded
      if (i == 7) begin
        w = 1;
        p = 3;
      end
      run_pulse(sels[i], i[0], w, p, divs[i]);
    end
    up_ctl = 8'h08;
    repeat (2) @(negedge mclk);
    c = count;
    repeat (20) @(negedge mclk);
    check_val("count without mode", c, count);
    up_ctl = 8'h00;
    @(negedge mclk);
    run_warm(8'h43, 8'h01, 16);
    run_warm(8'h43, 8'h02, 16);
    run_warm(8'h63, 8'h01, 1);
    close_out();
  end
endmodule // tb_cascaded_pulse_warmup_timer
`default_nettype wire
